// ### hw/rrs_exec.sv
// Purpose: Execute slice for returns, rotates through carry, halt and subtracts.
// Assumes: File operand data arrives with the instruction; stack top is valid when taken.
// Notes: Registers reached over AHB-Lite, zero wait states, always OKAY.
`timescale 1ns/1ps
module rrs_exec
    import rrs_pkg::*;
#(
    parameter int PC_W = 13
)
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Instruction issue
    input wire logic instr_valid_i,
    input wire logic [RRS_INSTR_W-1:0] instr_i,
    output logic instr_ready_o,
    input wire logic [RRS_DATA_W-1:0] file_rdata_i,
    // Return stack and program counter
    input wire logic [PC_W-1:0] stack_top_entry_i,
    output logic stack_pop_o,
    output logic pc_load_o,
    output logic [PC_W-1:0] pc_value_o,
    output logic fetch_discard_o,
    // Results
    output rrs_file_wr_t file_wr_o,
    output logic [RRS_DATA_W-1:0] acc_o,
    output rrs_flags_t flags_o,
    output logic elapsed_status_flag_o,
    output logic halted_status_flag_o,
    // Watchdog and oscillator
    output logic dog_timer_count_clear_o,
    output logic dog_prescale_clear_o,
    output logic osc_stop_o,
    input wire logic wake_i
);

    generate
        if (PC_W < 1 || PC_W > 16)
        begin : g_bad_pc
            $error("rrs_exec: PC_W must be 1..16");
        end
    endgenerate

    // ==========================================
    // Declarations
    // ==========================================
    rrs_state_t state_ff;
    rrs_state_t nxt_state;
    rrs_op_t op;
    logic take;
    logic dest_file;
    logic [RRS_FADDR_W-1:0] faddr;
    logic [RRS_DATA_W-1:0] literal;
    logic [RRS_DATA_W-1:0] sub_a;
    logic [RRS_DATA_W-1:0] sub_diff;
    rrs_flags_t sub_flags;
    logic [RRS_DATA_W-1:0] rot_res;
    logic rot_carry;

    logic [RRS_DATA_W-1:0] acc_ff;
    rrs_flags_t flags_ff;
    logic elapsed_ff;
    logic halted_ff;
    rrs_file_wr_t file_wr_ff;
    logic pc_load_ff;
    logic [PC_W-1:0] pc_value_ff;
    logic dog_clear_ff;

    logic wr_pend_ff;
    logic [RRS_DEC_W-1:0] wr_addr_ff;
    logic [31:0] hrdata_ff;
    logic addr_phase;
    logic sw_acc_we;
    logic sw_status_we;
    logic sw_wake;
    logic [31:0] rd_mux;

    // ==========================================
    // Decode
    // ==========================================
    always_comb
    begin
        op = RRS_OP_OTHER;
        if (instr_i[RRS_INSTR_W-1 -: $bits(RRS_OPC_RETLIT)] == RRS_OPC_RETLIT)
        begin
            op = RRS_OP_RETLIT;
        end
        else if (instr_i == RRS_OPC_RETURN)
        begin
            op = RRS_OP_RETURN;
        end
        else if (instr_i == RRS_OPC_HALT)
        begin
            op = RRS_OP_HALT;
        end
        else if (instr_i[RRS_INSTR_W-1 -: $bits(RRS_OPC_RRC)] == RRS_OPC_RRC)
        begin
            op = RRS_OP_RRC;
        end
        else if (instr_i[RRS_INSTR_W-1 -: $bits(RRS_OPC_RLC)] == RRS_OPC_RLC)
        begin
            op = RRS_OP_RLC;
        end
        else if (instr_i[RRS_INSTR_W-1 -: $bits(RRS_OPC_SUBFILE)] == RRS_OPC_SUBFILE)
        begin
            op = RRS_OP_SUBFILE;
        end
        else if (instr_i[RRS_INSTR_W-1 -: $bits(RRS_OPC_SUBLIT)] == RRS_OPC_SUBLIT)
        begin
            op = RRS_OP_SUBLIT;
        end
    end

    assign instr_ready_o = (state_ff == RRS_RUN);
    assign take = instr_valid_i & instr_ready_o;
    assign dest_file = instr_i[RRS_DEST_BIT];
    assign faddr = instr_i[RRS_FADDR_MSB:0];
    assign literal = instr_i[RRS_LIT_MSB:0];

    // ==========================================
    // Datapath
    // ==========================================
    assign sub_a = (op == RRS_OP_SUBLIT) ? literal : file_rdata_i;

    rrs_sub8 #(
        .W(RRS_DATA_W)
    ) u_sub (
        .minuend_i(sub_a),
        .subtrahend_i(acc_ff),
        .diff_o(sub_diff),
        .flags_o(sub_flags)
    );

    always_comb
    begin
        if (op == RRS_OP_RRC)
        begin
            rot_res = {flags_ff.carry, file_rdata_i[RRS_DATA_W-1:1]};
            rot_carry = file_rdata_i[0];
        end
        else
        begin
            rot_res = {file_rdata_i[RRS_DATA_W-2:0], flags_ff.carry};
            rot_carry = file_rdata_i[RRS_DATA_W-1];
        end
    end

    // ==========================================
    // Sequencer
    // ==========================================
    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            RRS_RUN:
            begin
                if (take && (op == RRS_OP_RETLIT || op == RRS_OP_RETURN))
                begin
                    nxt_state = RRS_RET_FLUSH;
                end
                else if (take && op == RRS_OP_HALT)
                begin
                    nxt_state = RRS_SLEEP;
                end
            end
            RRS_RET_FLUSH:
            begin
                nxt_state = RRS_RUN;
            end
            RRS_SLEEP:
            begin
                if (wake_i || sw_wake)
                begin
                    nxt_state = RRS_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_ff <= RRS_RUN;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // ==========================================
    // Program counter and stack
    // ==========================================
    // Pulses last the second cycle of the two, the one after the take; the next cycle refetches
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pc_load_ff <= 1'b0;
            pc_value_ff <= '0;
        end
        else
        begin
            pc_load_ff <= take && (op == RRS_OP_RETLIT || op == RRS_OP_RETURN);
            if (take && (op == RRS_OP_RETLIT || op == RRS_OP_RETURN))
            begin
                pc_value_ff <= stack_top_entry_i;
            end
        end
    end

    assign pc_load_o = pc_load_ff;
    assign stack_pop_o = pc_load_ff;
    assign fetch_discard_o = pc_load_ff;
    assign pc_value_o = pc_value_ff;

    // ==========================================
    // Accumulator
    // ==========================================
    // Instruction write wins over a same-cycle bus write
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            acc_ff <= RRS_ACC_RST;
        end
        else if (take && op == RRS_OP_RETLIT)
        begin
            acc_ff <= literal;
        end
        else if (take && op == RRS_OP_SUBLIT)
        begin
            acc_ff <= sub_diff;
        end
        else if (take && op == RRS_OP_SUBFILE && !dest_file)
        begin
            acc_ff <= sub_diff;
        end
        else if (take && (op == RRS_OP_RRC || op == RRS_OP_RLC) && !dest_file)
        begin
            acc_ff <= rot_res;
        end
        else if (sw_acc_we)
        begin
            acc_ff <= hwdata_i[RRS_DATA_W-1:0];
        end
    end

    assign acc_o = acc_ff;

    // ==========================================
    // Arithmetic flags
    // ==========================================
    // Returns leave flags alone by falling through
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            flags_ff <= '0;
        end
        else if (take && (op == RRS_OP_SUBLIT || op == RRS_OP_SUBFILE))
        begin
            flags_ff <= sub_flags;
        end
        else if (take && (op == RRS_OP_RRC || op == RRS_OP_RLC))
        begin
            flags_ff.carry <= rot_carry;
        end
        else if (sw_status_we)
        begin
            flags_ff.carry <= hwdata_i[RRS_ST_CARRY];
            flags_ff.nibble_carry_flag <= hwdata_i[RRS_ST_NIBBLE];
            flags_ff.zero <= hwdata_i[RRS_ST_ZERO];
        end
    end

    assign flags_o = flags_ff;

    // ==========================================
    // File write-back
    // ==========================================
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            file_wr_ff <= '0;
        end
        else
        begin
            file_wr_ff.we <= take && dest_file
                && (op == RRS_OP_RRC || op == RRS_OP_RLC || op == RRS_OP_SUBFILE);
            file_wr_ff.addr <= faddr;
            file_wr_ff.data <= (op == RRS_OP_SUBFILE) ? sub_diff : rot_res;
        end
    end

    assign file_wr_o = file_wr_ff;

    // ==========================================
    // Halt, watchdog and power status
    // ==========================================
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            elapsed_ff <= RRS_ELAPSED_RST;
            halted_ff <= RRS_HALTED_RST;
            dog_clear_ff <= 1'b0;
        end
        else
        begin
            dog_clear_ff <= take && op == RRS_OP_HALT;
            if (take && op == RRS_OP_HALT)
            begin
                elapsed_ff <= 1'b1;
                halted_ff <= 1'b0;
            end
        end
    end

    assign elapsed_status_flag_o = elapsed_ff;
    assign halted_status_flag_o = halted_ff;
    assign dog_timer_count_clear_o = dog_clear_ff;
    assign dog_prescale_clear_o = dog_clear_ff;
    assign osc_stop_o = (state_ff == RRS_SLEEP);

    // ==========================================
    // AHB-Lite slave
    // ==========================================
    // Zero wait states keep the bus simple; reads show state at the address edge
    assign addr_phase = hsel_i && hready_i && (htrans_i == RRS_HTRANS_NONSEQ || htrans_i[1]);
    assign sw_acc_we = wr_pend_ff && (wr_addr_ff == RRS_ADDR_ACC);
    assign sw_status_we = wr_pend_ff && (wr_addr_ff == RRS_ADDR_STATUS);
    assign sw_wake = wr_pend_ff && (wr_addr_ff == RRS_ADDR_CTRL) && hwdata_i[RRS_CTRL_WAKE];

    always_comb
    begin
        rd_mux = '0;
        unique case (haddr_i[RRS_DEC_W-1:0])
            RRS_ADDR_ACC:
            begin
                rd_mux[RRS_DATA_W-1:0] = acc_ff;
            end
            RRS_ADDR_STATUS:
            begin
                rd_mux[RRS_ST_CARRY] = flags_ff.carry;
                rd_mux[RRS_ST_NIBBLE] = flags_ff.nibble_carry_flag;
                rd_mux[RRS_ST_ZERO] = flags_ff.zero;
                rd_mux[RRS_ST_HALTED] = halted_ff;
                rd_mux[RRS_ST_ELAPSED] = elapsed_ff;
                rd_mux[RRS_ST_SLEEPING] = (state_ff == RRS_SLEEP);
            end
            default:
            begin
                rd_mux = '0;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= '0;
            hrdata_ff <= '0;
        end
        else
        begin
            wr_pend_ff <= addr_phase && hwrite_i;
            if (addr_phase)
            begin
                wr_addr_ff <= haddr_i[RRS_DEC_W-1:0];
            end
            if (addr_phase && !hwrite_i)
            begin
                hrdata_ff <= rd_mux;
            end
        end
    end

    assign hrdata_o = hrdata_ff;
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;

endmodule

// ### inc/rrs_pkg.sv
// Purpose: Shared constants and types for the return/rotate/subtract execute slice.
// Assumes: 14-bit instruction words, 8-bit data, 32-bit AHB-Lite register port.
// Notes: Contract list below.
// Contract
// - Literal return loads accumulator, pops top to counter
// - Literal return: one word, two cycles
// - Plain return pops stack; two cycles; flags unchanged
// - Rotate right through carry, one cycle
// - Rotate left through carry, one cycle
// - Destination bit: 0 accumulator, 1 file
// - File operand is 7 bits, 0..127
// - Halt clears dog timer/prescaler, sets elapsed, clears halted
// - Halt enters low power, oscillator stopped
// - Literal minus accumulator into accumulator, flags updated
// - File minus accumulator to destination, flags updated
// - No borrow leaves carry set
// - Borrow clears carry, result wraps
// - Zero result sets carry and zero
package rrs_pkg;

    // ==========================================
    // Widths and instruction fields
    // ==========================================
    localparam int RRS_DATA_W = 8;
    localparam int RRS_INSTR_W = 14;
    localparam int RRS_FADDR_W = 7;
    localparam int RRS_DEST_BIT = 7;
    localparam int RRS_LIT_MSB = 7;
    localparam int RRS_FADDR_MSB = 6;
    localparam int RRS_NIB_W = 4;

    // ==========================================
    // Opcodes
    // ==========================================
    localparam logic [3:0] RRS_OPC_RETLIT = 4'hd;
    localparam logic [13:0] RRS_OPC_RETURN = 14'h0008;
    localparam logic [13:0] RRS_OPC_HALT = 14'h0063;
    localparam logic [5:0] RRS_OPC_RRC = 6'h0c;
    localparam logic [5:0] RRS_OPC_RLC = 6'h0d;
    localparam logic [5:0] RRS_OPC_SUBFILE = 6'h02;
    localparam logic [4:0] RRS_OPC_SUBLIT = 5'h1e;

    // ==========================================
    // Register map and fields
    // ==========================================
    localparam int RRS_DEC_W = 8;
    localparam logic [7:0] RRS_ADDR_ACC = 8'h00;
    localparam logic [7:0] RRS_ADDR_STATUS = 8'h04;
    localparam logic [7:0] RRS_ADDR_CTRL = 8'h08;
    localparam int RRS_ST_CARRY = 0;
    localparam int RRS_ST_NIBBLE = 1;
    localparam int RRS_ST_ZERO = 2;
    localparam int RRS_ST_HALTED = 3;
    localparam int RRS_ST_ELAPSED = 4;
    localparam int RRS_ST_SLEEPING = 5;
    localparam int RRS_CTRL_WAKE = 0;

    localparam logic [7:0] RRS_ACC_RST = 8'h00;
    localparam logic RRS_HALTED_RST = 1'b1;
    localparam logic RRS_ELAPSED_RST = 1'b1;
    localparam logic [1:0] RRS_HTRANS_NONSEQ = 2'h2;

    // ==========================================
    // Types
    // ==========================================
    typedef struct packed {
        logic zero;
        logic nibble_carry_flag;
        logic carry;
    } rrs_flags_t;

    typedef struct packed {
        logic we;
        logic [RRS_FADDR_W-1:0] addr;
        logic [RRS_DATA_W-1:0] data;
    } rrs_file_wr_t;

    typedef enum logic [1:0] {
        RRS_RUN,
        RRS_RET_FLUSH,
        RRS_SLEEP
    } rrs_state_t;

    typedef enum logic [2:0] {
        RRS_OP_OTHER,
        RRS_OP_RETLIT,
        RRS_OP_RETURN,
        RRS_OP_RRC,
        RRS_OP_RLC,
        RRS_OP_HALT,
        RRS_OP_SUBLIT,
        RRS_OP_SUBFILE
    } rrs_op_t;

endpackage

// ### hw/rrs_sub8.sv
// Purpose: Two's complement subtractor with carry, nibble carry and zero.
// Assumes: Carry means no borrow, as in the core's subtract convention.
// Notes: Purely combinational.
`timescale 1ns/1ps
module rrs_sub8
    import rrs_pkg::*;
#(
    parameter int W = RRS_DATA_W
)
(
    input wire logic [W-1:0] minuend_i,
    input wire logic [W-1:0] subtrahend_i,
    output logic [W-1:0] diff_o,
    output rrs_flags_t flags_o
);

    // Nibble carry needs a full low nibble below the msb
    generate
        if (W <= RRS_NIB_W)
        begin : g_bad_width
            $error("rrs_sub8: W must exceed the nibble width");
        end
    endgenerate

    logic [W:0] full;
    logic [RRS_NIB_W:0] low;

    // ==========================================
    // Subtract
    // ==========================================
    always_comb
    begin
        full = {1'b0, minuend_i} - {1'b0, subtrahend_i};
        low = {1'b0, minuend_i[RRS_NIB_W-1:0]} - {1'b0, subtrahend_i[RRS_NIB_W-1:0]};
        diff_o = full[W-1:0];
        flags_o.carry = ~full[W];
        flags_o.nibble_carry_flag = ~low[RRS_NIB_W];
        flags_o.zero = (full[W-1:0] == '0);
    end

endmodule

// ### bench/rrs_exec_assertions.sv
// Purpose: Port-level checks on the execute slice.
// Assumes: One clock, async active-low reset.
// Notes: Bound into every rrs_exec instance.
`timescale 1ns/1ps
module rrs_exec_checker
    import rrs_pkg::*;
#(
    parameter int PC_W = 13
)
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic instr_valid_i,
    input wire logic [RRS_INSTR_W-1:0] instr_i,
    input wire logic instr_ready_o,
    input wire logic [RRS_DATA_W-1:0] file_rdata_i,
    input wire logic [PC_W-1:0] stack_top_entry_i,
    input wire logic stack_pop_o,
    input wire logic pc_load_o,
    input wire logic [PC_W-1:0] pc_value_o,
    input wire logic fetch_discard_o,
    input wire rrs_file_wr_t file_wr_o,
    input wire logic [RRS_DATA_W-1:0] acc_o,
    input wire rrs_flags_t flags_o,
    input wire logic elapsed_status_flag_o,
    input wire logic halted_status_flag_o,
    input wire logic dog_timer_count_clear_o,
    input wire logic dog_prescale_clear_o,
    input wire logic osc_stop_o
);
    logic taken;
    assign taken = instr_valid_i & instr_ready_o;
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);
    // ==========================================
    // Checks
    ret_pop_a: assert property (taken && instr_i == RRS_OPC_RETURN
        |=> stack_pop_o && pc_load_o && pc_value_o == $past(stack_top_entry_i) && $stable(flags_o))
        else $error("plain return result");
    retlit_a: assert property (taken && instr_i[13:10] == RRS_OPC_RETLIT
        |=> stack_pop_o && acc_o == $past(instr_i[7:0]) && pc_value_o == $past(stack_top_entry_i))
        else $error("literal return result");
    refetch_a: assert property (pc_load_o |-> fetch_discard_o && !instr_ready_o ##1 instr_ready_o)
        else $error("return refetch timing");
    rrc_a: assert property (taken && instr_i[13:7] == {RRS_OPC_RRC, 1'b0}
        |=> acc_o == {$past(flags_o.carry), $past(file_rdata_i[7:1])} && flags_o.carry == $past(file_rdata_i[0]))
        else $error("rotate right result");
    rlc_a: assert property (taken && instr_i[13:7] == {RRS_OPC_RLC, 1'b1}
        |=> file_wr_o == {1'b1, $past(instr_i[6:0]), $past(file_rdata_i[6:0]), $past(flags_o.carry)})
        else $error("rotate left write-back");
    halt_a: assert property (taken && instr_i == RRS_OPC_HALT
        |=> dog_timer_count_clear_o && dog_prescale_clear_o && elapsed_status_flag_o && !halted_status_flag_o
        && osc_stop_o && !instr_ready_o)
        else $error("halt effects");
    sublit_a: assert property (taken && instr_i[13:9] == RRS_OPC_SUBLIT
        |=> acc_o == 8'($past(instr_i[7:0]) - $past(acc_o)) && flags_o.zero == (acc_o == 8'h00)
        && flags_o.carry == ($past(instr_i[7:0]) >= $past(acc_o)))
        else $error("literal subtract result");
    subfile_a: assert property (taken && instr_i[13:8] == RRS_OPC_SUBFILE
        |=> ($past(instr_i[7]) ? file_wr_o.data : acc_o) == 8'($past(file_rdata_i) - $past(acc_o))
        && flags_o.nibble_carry_flag == ($past(file_rdata_i[3:0]) >= $past(acc_o[3:0])))
        else $error("file subtract result");
endmodule

bind rrs_exec rrs_exec_checker #(.PC_W(PC_W)) chk_u (.*);

// ### bench/rrs_stack_model.sv
// Purpose: Return stack seen by the execute slice.
// Assumes: Top entry valid at all times.
// Notes: Entries fixed at reset; a pop wraps at the bottom.
`timescale 1ns/1ps
module rrs_stack_model
#(
    parameter int PC_W = 13,
    parameter int DEPTH = 4
)
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic stack_pop_i,
    output logic [PC_W-1:0] stack_top_entry_o
);
    logic [PC_W-1:0] entry_ff [DEPTH];
    int unsigned sp_ff;
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sp_ff <= DEPTH - 1;
            for (int i = 0; i < DEPTH; i++)
                entry_ff[i] <= PC_W'(32'h0a40 + 32'h11 * i);
        end
        else if (stack_pop_i)
            sp_ff <= (sp_ff == 0) ? DEPTH - 1 : sp_ff - 1;
    end
    // Distinct entries, so a stale top is caught
    assign stack_top_entry_o = entry_ff[sp_ff];
endmodule

// ### bench/return_rotate_subtract_exec_test.sv
// Purpose: Self-checking bench for the execute slice.
// Assumes: One AHB-Lite master, zero-wait slave.
// Notes: Inputs change by NBA on rising edges.
`timescale 1ns/1ps
module return_rotate_subtract_exec_test;
    import rrs_pkg::*;
    localparam int PC_W = 13;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic hsel_i = 1'b0;
    logic hwrite_i = 1'b0;
    logic [31:0] haddr_i = 32'h0;
    logic [1:0] htrans_i = 2'h0;
    logic [2:0] hsize_i = 3'h2;
    logic [31:0] hwdata_i = 32'h0;
    logic hready_i;
    logic [31:0] hrdata_o;
    logic hreadyout_o, hresp_o, instr_ready_o, stack_pop_o, pc_load_o, fetch_discard_o, osc_stop_o;
    logic instr_valid_i = 1'b0;
    logic wake_i = 1'b0;
    logic [RRS_INSTR_W-1:0] instr_i = 14'h0;
    logic [RRS_DATA_W-1:0] file_rdata_i = 8'h0;
    logic [RRS_DATA_W-1:0] acc_o;
    logic [PC_W-1:0] stack_top_entry_i, pc_value_o, top_q;
    rrs_file_wr_t file_wr_o;
    rrs_flags_t flags_o;
    logic elapsed_status_flag_o, halted_status_flag_o, dog_timer_count_clear_o, dog_prescale_clear_o;
    int n_fail = 0;
    int tests_run = 0;
    assign hready_i = hreadyout_o;
    rrs_exec #(.PC_W(PC_W)) dut_u (.*);
    rrs_stack_model #(.PC_W(PC_W)) stack_u (
        .clock_i,
        .rst_n_i,
        .stack_pop_i(stack_pop_o),
        .stack_top_entry_o(stack_top_entry_i)
    );
    always #25 clock_i = ~clock_i;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clock_i);
        hsel_i <= 1'b1;
        haddr_i <= {24'h0, a};
        htrans_i <= RRS_HTRANS_NONSEQ;
        hwrite_i <= wr;
        do @(posedge clock_i); while (hready_i !== 1'b1);
        htrans_i <= 2'h0;
        hwdata_i <= wd;
        do @(posedge clock_i); while (hready_i !== 1'b1);
        rd = hrdata_o;
        hsel_i <= 1'b0;
    endtask

    // Holds the word until taken; results are looked at one cycle on
    task automatic issue(input logic [13:0] ins, input logic [7:0] fd);
        while (instr_ready_o !== 1'b1)
            @(negedge clock_i);
        @(posedge clock_i);
        instr_valid_i <= 1'b1;
        instr_i <= ins;
        file_rdata_i <= fd;
        @(negedge clock_i);
        top_q = stack_top_entry_i;
        @(posedge clock_i);
        instr_valid_i <= 1'b0;
        @(negedge clock_i);
    endtask

    task automatic t_sub;
        logic [7:0] ks[4] = '{8'h02, 8'h02, 8'h02, 8'h10};
        logic [7:0] as[4] = '{8'h01, 8'h02, 8'h03, 8'h01};
        logic [7:0] res;
        logic [31:0] rd;
        ahb(1'b0, RRS_ADDR_STATUS, 32'h0, rd);
        check(rd, 32'h18);
        check({hreadyout_o, hresp_o}, 2'b10);
        ahb(1'b1, 8'h0c, 32'h5a, rd);
        ahb(1'b0, 8'h0c, 32'h0, rd);
        check(rd, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            ahb(1'b1, RRS_ADDR_ACC, {24'h0, as[i]}, rd);
            issue({RRS_OPC_SUBLIT, i[0], ks[i]}, 8'h00);
            res = ks[i] - as[i];
            check(acc_o, res);
            check(flags_o, {res == 8'h00, ks[i][3:0] >= as[i][3:0], ks[i] >= as[i]});
        end
        // Accumulator holds 0f from the last literal subtract
        issue({RRS_OPC_SUBFILE, 1'b1, 7'h7f}, 8'h0f);
        check(file_wr_o, {1'b1, 7'h7f, 8'h00});
        check(acc_o, 8'h0f);
        issue({RRS_OPC_SUBFILE, 1'b0, 7'h00}, 8'h0e);
        check({acc_o, flags_o}, {8'hff, 3'b000});
        $display("test subtract done");
    endtask

    task automatic t_rot;
        logic [31:0] rd;
        ahb(1'b1, RRS_ADDR_STATUS, 32'h0, rd);
        issue({RRS_OPC_RRC, 1'b0, 7'h11}, 8'he6);
        check({acc_o, flags_o.carry}, {8'h73, 1'b0});
        issue({RRS_OPC_RLC, 1'b1, 7'h22}, 8'he6);
        check({file_wr_o, flags_o.carry}, {1'b1, 7'h22, 8'hcc, 1'b1});
        issue({RRS_OPC_RRC, 1'b1, 7'h33}, 8'h01);
        check({file_wr_o, flags_o.carry}, {1'b1, 7'h33, 8'h80, 1'b1});
        issue({RRS_OPC_RLC, 1'b0, 7'h44}, 8'h00);
        check({acc_o, flags_o.carry, file_wr_o.we}, {8'h01, 1'b0, 1'b0});
        $display("test rotate done");
    endtask

    task automatic t_ret;
        logic [31:0] rd;
        ahb(1'b1, RRS_ADDR_STATUS, 32'h5, rd);
        issue({RRS_OPC_RETLIT, 2'b10, 8'h3c}, 8'h00);
        check({acc_o, pc_value_o, flags_o}, {8'h3c, top_q, 3'h5});
        check({stack_pop_o, pc_load_o, fetch_discard_o, instr_ready_o}, 4'he);
        @(negedge clock_i);
        check({pc_load_o, instr_ready_o}, 2'b01);
        // Unknown opcode as filler, so the stack has popped before the next return
        issue(14'h0000, 8'h00);
        issue(RRS_OPC_RETURN, 8'h00);
        check({acc_o, pc_value_o, flags_o}, {8'h3c, top_q, 3'h5});
        check({stack_pop_o, pc_load_o, fetch_discard_o, instr_ready_o}, 4'he);
        $display("test return done");
    endtask

    task automatic t_halt(input logic by_pin);
        logic [31:0] rd;
        issue(RRS_OPC_HALT, 8'h00);
        check({dog_timer_count_clear_o, dog_prescale_clear_o, elapsed_status_flag_o, halted_status_flag_o}, 4'he);
        check({osc_stop_o, instr_ready_o}, 2'b10);
        ahb(1'b0, RRS_ADDR_STATUS, 32'h0, rd);
        check(rd[5:3], 3'b110);
        if (by_pin)
        begin
            @(posedge clock_i);
            wake_i <= 1'b1;
            @(posedge clock_i);
            wake_i <= 1'b0;
        end
        else
            ahb(1'b1, RRS_ADDR_CTRL, 32'h1, rd);
        @(negedge clock_i);
        for (int i = 0; i < 3 && osc_stop_o !== 1'b0; i++)
            @(negedge clock_i);
        check({osc_stop_o, instr_ready_o, halted_status_flag_o}, 3'b010);
        $display("test halt done");
    endtask

    initial
    begin
        repeat (5) @(posedge clock_i);
        rst_n_i <= 1'b1;
        t_sub();
        t_rot();
        t_ret();
        t_halt(1'b0);
        t_halt(1'b1);
        tally_and_finish();
    end

    // Whole run needs well under a thousand cycles
    initial
    begin
        #(50 * 3000);
        n_fail++;
        $display("watchdog expired");
        tally_and_finish();
    end
endmodule
